// >>> design/mbs_slave_port.sv
// Configurable serial slave port: receiver, frame end detection, address filter,
// reply gating with response delay, timeout supervision and transmitter.
// Assumes rxd_i is already synchronous to clk_i and idles high.
`timescale 1ns/1ps
// Operation
// - Protocol setting 0 selects Modbus, the only protocol, also the reset value.
// - Baud codes 0..7 give 300..38400 bit/s; code 5 after reset.
// - Framing 0=8N2, 1=8E1, 2=8O1, 3=8N1; reset value 0.
// - Station address settable 0..247, reset value 1.
// - Station address 0 acts as the broadcast address.
// - Reply delay 0..20 ms, default 2 ms, counted from request end.
// - Reply starts after both processing and delay have finished.
// - Timeout setting 0.1..60.0 s; zero, the default, disables supervision.
// - Gap between messages longer than the timeout raises the comm fault.
// - Reply format 1 standard, 0 adds one byte to every read reply.
// - Current readings scaled in 0.01 A (0, default) or 0.1 A (1).
// - Comm fault shows as fault code 0010 hex.
module mbs_slave_port #(
  parameter int CLK_HZ = mbs_pkg::CLK_HZ,
  parameter int MS_CYCLES = mbs_pkg::MS_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_we_i,
  input wire logic [1:0] cfg_proto_i,
  input wire logic [2:0] cfg_baud_i,
  input wire logic [1:0] cfg_fmt_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [4:0] cfg_dly_ms_i,
  input wire logic [9:0] cfg_tmo_i,
  input wire logic cfg_std_fmt_i,
  input wire logic cfg_cur_res_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic rx_frame_end_o,
  output logic rx_frame_ok_o,
  output logic rx_bcast_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  output logic reply_pending_o,
  output logic ext_reply_o,
  input wire logic [15:0] current_i,
  output logic [15:0] current_o,
  input wire logic fault_clr_i,
  output logic comm_timeout_fault_o,
  output logic [15:0] fault_code_o
);
  typedef enum logic [1:0] {
    MBS_RX_IDLE = 2'b00,
    MBS_RX_START = 2'b01,
    MBS_RX_DATA = 2'b10,
    MBS_RX_STOP = 2'b11
  } mbs_rx_t;

  localparam int MSW = $clog2(MS_CYCLES + 1);

  function automatic logic [19:0] bit_cycles(input logic [2:0] code);
    bit_cycles = 20'(CLK_HZ / mbs_pkg::baud_rate(code));
  endfunction

  function automatic logic [15:0] scale_current(input logic [15:0] cur, input logic coarse);
    scale_current = coarse ? (cur / mbs_pkg::CUR_DIV) : cur;
  endfunction

  // Configuration
  logic [1:0] proto;
  logic [2:0] baud;
  logic [1:0] fmt;
  logic [7:0] addr;
  logic [4:0] dly_ms;
  logic [9:0] tmo;
  logic std_fmt;
  logic cur_res;

  // Out-of-range address, delay and timeout values are ignored rather than clamped, so a bad write keeps the old value; protocol is stored as written
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      proto <= mbs_pkg::RST_PROTO;
      baud <= mbs_pkg::RST_BAUD;
      fmt <= mbs_pkg::RST_FMT;
      addr <= mbs_pkg::RST_ADDR;
      dly_ms <= mbs_pkg::RST_DLY_MS;
      tmo <= mbs_pkg::RST_TMO;
      std_fmt <= mbs_pkg::RST_STD_FMT;
      cur_res <= mbs_pkg::RST_CUR_RES;
    end else if (cfg_we_i) begin
      proto <= cfg_proto_i;
      baud <= cfg_baud_i;
      fmt <= cfg_fmt_i;
      addr <= (cfg_addr_i <= mbs_pkg::MAX_ADDR) ? cfg_addr_i : addr;
      dly_ms <= (cfg_dly_ms_i <= mbs_pkg::MAX_DLY_MS) ? cfg_dly_ms_i : dly_ms;
      tmo <= (cfg_tmo_i <= mbs_pkg::MAX_TMO) ? cfg_tmo_i : tmo;
      std_fmt <= cfg_std_fmt_i;
      cur_res <= cfg_cur_res_i;
    end
  end

  // Derived framing
  wire proto_ok = (proto == mbs_pkg::PROTO_MODBUS);
  wire [19:0] bit_cyc = bit_cycles(baud);
  wire has_par = (fmt == mbs_pkg::FMT_8E1) || (fmt == mbs_pkg::FMT_8O1);
  wire odd_par = (fmt == mbs_pkg::FMT_8O1);
  wire [3:0] char_bits = (fmt == mbs_pkg::FMT_8N1) ? mbs_pkg::CHAR_BITS_10 :
                                                     mbs_pkg::CHAR_BITS_11;
  wire [5:0] sil_bits = (fmt == mbs_pkg::FMT_8N1) ? mbs_pkg::SIL_BITS_10 :
                                                    mbs_pkg::SIL_BITS_11;
  wire [25:0] sil_cyc = 26'(bit_cyc * sil_bits);

  // Receiver
  mbs_rx_t rx_state;
  logic [19:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [8:0] rx_sh;
  wire rx_tick = (rx_cnt == '0);
  wire [3:0] rx_nbits = has_par ? 4'h9 : 4'h8;
  wire [7:0] rx_byte = has_par ? rx_sh[7:0] : rx_sh[8:1];
  wire par_bad = has_par && ((^rx_byte ^ rx_sh[8]) != odd_par);
  wire byte_done = (rx_state == MBS_RX_STOP) && rx_tick;
  wire byte_bad = byte_done && (!rxd_i || par_bad);
  wire frame_start = (rx_state == MBS_RX_IDLE) && !rxd_i && proto_ok;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_state <= MBS_RX_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
    end else begin
      rx_cnt <= rx_tick ? bit_cyc - 20'h1 : rx_cnt - 20'h1;
      case (rx_state)
        MBS_RX_IDLE: begin
          if (frame_start) begin
            rx_state <= MBS_RX_START;
            rx_cnt <= {1'b0, bit_cyc[19:1]};
          end
        end
        MBS_RX_START: begin
          if (rx_tick) begin
            rx_state <= rxd_i ? MBS_RX_IDLE : MBS_RX_DATA;
            rx_bit <= '0;
          end
        end
        MBS_RX_DATA: begin
          if (rx_tick) begin
            rx_sh <= {rxd_i, rx_sh[8:1]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == rx_nbits - 4'h1) begin
              rx_state <= MBS_RX_STOP;
            end
          end
        end
        MBS_RX_STOP: begin
          // Only the first stop bit is checked so that 8N2 masters with short gaps still pass
          if (rx_tick) begin
            rx_state <= MBS_RX_IDLE;
          end
        end
        default: rx_state <= MBS_RX_IDLE;
      endcase
    end
  end

  // Frame tracking and address filter
  logic in_frame;
  logic first_byte;
  logic frm_match;
  logic frm_bcast;
  logic frm_err;
  logic [25:0] sil_cnt;
  wire line_quiet = (rx_state == MBS_RX_IDLE) && rxd_i;
  wire eof = in_frame && line_quiet && (sil_cnt >= sil_cyc);
  wire byte_is_bcast = (rx_byte == mbs_pkg::BCAST_ADDR);
  wire byte_match = byte_is_bcast || (rx_byte == addr);
  wire push_byte = byte_done && (first_byte ? byte_match : frm_match);
  wire fifo_in_ready;
  wire overrun = push_byte && !fifo_in_ready;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      in_frame <= 1'b0;
      first_byte <= 1'b1;
      frm_match <= 1'b0;
      frm_bcast <= 1'b0;
      frm_err <= 1'b0;
      sil_cnt <= '0;
    end else begin
      sil_cnt <= line_quiet ? ((sil_cnt == '1) ? sil_cnt : sil_cnt + 26'h1) : '0;
      if (frame_start && !in_frame) begin
        in_frame <= 1'b1;
        first_byte <= 1'b1;
        frm_err <= 1'b0;
      end else if (eof) begin
        in_frame <= 1'b0;
      end
      if (byte_done) begin
        first_byte <= 1'b0;
        if (first_byte) begin
          frm_match <= byte_match;
          frm_bcast <= byte_is_bcast;
        end
      end
      if (byte_bad || overrun) begin
        frm_err <= 1'b1;
      end
    end
  end

  // Received bytes of addressed frames; a full buffer drops the byte and spoils the frame
  mbs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(rx_byte),
    .in_valid_i(push_byte),
    .in_ready_o(fifo_in_ready),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // Millisecond time base restarted at each frame end
  logic [MSW-1:0] ms_pre;
  logic [15:0] ms_cnt;
  logic tmo_run;
  wire ms_tick = (ms_pre == MSW'(MS_CYCLES - 1));
  wire dly_done = (ms_cnt >= {11'h000, dly_ms});
  wire [16:0] tmo_ms = 17'(tmo * mbs_pkg::TMO_UNIT_MS);
  wire tmo_hit = tmo_run && (tmo != '0) && ({1'b0, ms_cnt} > tmo_ms);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ms_pre <= '0;
      ms_cnt <= '0;
      tmo_run <= 1'b0;
    end else if (eof) begin
      ms_pre <= '0;
      ms_cnt <= '0;
      tmo_run <= 1'b1;
    end else begin
      ms_pre <= ms_tick ? '0 : ms_pre + 1'b1;
      if (ms_tick && ms_cnt != '1) begin
        ms_cnt <= ms_cnt + 16'h1;
      end
      tmo_run <= tmo_run && !frame_start;
    end
  end

  // Fault flag: a new timeout in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      comm_timeout_fault_o <= 1'b0;
    end else begin
      comm_timeout_fault_o <= tmo_hit || (comm_timeout_fault_o && !fault_clr_i);
    end
  end
  assign fault_code_o = comm_timeout_fault_o ? mbs_pkg::FAULT_COMM :
                                               mbs_pkg::FAULT_NONE;

  // Reply gating
  logic [10:0] tx_sh;
  logic [3:0] tx_left;
  logic [19:0] tx_cnt;
  logic tx_busy;
  wire tx_tick = (tx_cnt == '0);
  wire reply_ok = frm_match && !frm_bcast && !frm_err && proto_ok;
  assign tx_ready_o = reply_pending_o && dly_done && !tx_busy && !in_frame;
  wire tx_take = tx_valid_i && tx_ready_o;
  wire tx_par = odd_par ? ~^tx_data_i : ^tx_data_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reply_pending_o <= 1'b0;
      rx_frame_end_o <= 1'b0;
      rx_frame_ok_o <= 1'b0;
      rx_bcast_o <= 1'b0;
    end else begin
      rx_frame_end_o <= eof;
      if (eof) begin
        reply_pending_o <= reply_ok;
        rx_frame_ok_o <= frm_match && !frm_err;
        rx_bcast_o <= frm_bcast;
      end else if (frame_start || (tx_take && tx_last_i)) begin
        reply_pending_o <= 1'b0;
      end
    end
  end

  // Transmitter: start, 8 data bits LSB first, parity or stop, then stop except in 8N1
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_sh <= '1;
      tx_left <= '0;
      tx_cnt <= '0;
      tx_busy <= 1'b0;
      txd_o <= 1'b1;
      txd_oe_o <= 1'b0;
    end else begin
      txd_o <= tx_sh[0];
      txd_oe_o <= tx_busy;
      if (tx_take) begin
        tx_sh <= {1'b1, has_par ? tx_par : 1'b1, tx_data_i, 1'b0};
        tx_left <= char_bits;
        tx_cnt <= bit_cyc - 20'h1;
        tx_busy <= 1'b1;
      end else if (tx_busy) begin
        tx_cnt <= tx_tick ? bit_cyc - 20'h1 : tx_cnt - 20'h1;
        if (tx_tick) begin
          tx_sh <= {1'b1, tx_sh[10:1]};
          tx_left <= tx_left - 4'h1;
          tx_busy <= (tx_left != 4'h1);
        end
      end
    end
  end

  // Reply format and current scaling for the reply builder
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ext_reply_o <= 1'b0;
      current_o <= '0;
    end else begin
      ext_reply_o <= !std_fmt;
      current_o <= scale_current(current_i, cur_res);
    end
  end
endmodule

// >>> design/mbs_pkg.sv
// Shared constants of the configurable serial slave port.
// Assumes a single 100 MHz system clock; all counts are derived from it.
package mbs_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  // Protocol selection
  localparam logic [1:0] PROTO_MODBUS = 2'h0;
  // Character framing codes
  localparam logic [1:0] FMT_8N2 = 2'h0;
  localparam logic [1:0] FMT_8E1 = 2'h1;
  localparam logic [1:0] FMT_8O1 = 2'h2;
  localparam logic [1:0] FMT_8N1 = 2'h3;
  // Reset values of the configuration
  localparam logic [1:0] RST_PROTO = PROTO_MODBUS;
  localparam logic [2:0] RST_BAUD = 3'h5;
  localparam logic [1:0] RST_FMT = FMT_8N2;
  localparam logic [7:0] RST_ADDR = 8'h01;
  localparam logic [4:0] RST_DLY_MS = 5'h02;
  localparam logic [9:0] RST_TMO = 10'h000;
  localparam logic RST_STD_FMT = 1'b1;
  localparam logic RST_CUR_RES = 1'b0;
  // Legal ranges
  localparam logic [7:0] MAX_ADDR = 8'hf7;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [4:0] MAX_DLY_MS = 5'h14;
  localparam logic [9:0] MAX_TMO = 10'h258;
  // Timeout setting counts in 0.1 s steps
  localparam logic [6:0] TMO_UNIT_MS = 7'h64;
  // Fault codes
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_COMM = 16'h0010;
  // Character lengths in bit times, and 3.5 characters rounded up
  localparam logic [3:0] CHAR_BITS_11 = 4'hb;
  localparam logic [3:0] CHAR_BITS_10 = 4'ha;
  localparam logic [5:0] SIL_BITS_11 = 6'h27;
  localparam logic [5:0] SIL_BITS_10 = 6'h23;
  // Current scaling divisor for the coarse resolution
  localparam logic [15:0] CUR_DIV = 16'h000a;

  function automatic int baud_rate(input logic [2:0] code);
    case (code)
      3'h0: baud_rate = 300;
      3'h1: baud_rate = 600;
      3'h2: baud_rate = 1200;
      3'h3: baud_rate = 2400;
      3'h4: baud_rate = 4800;
      3'h5: baud_rate = 9600;
      3'h6: baud_rate = 19200;
      default: baud_rate = 38400;
    endcase
  endfunction
endpackage

// >>> design/mbs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module mbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> sim/mbs_slave_port_checker.sv
// Assertions on the ports of the serial slave port.
// Assumes the bench's shortened ms count is passed on through the bind.
`timescale 1ns/1ps
module mbs_slave_port_checker #(
  parameter int MS_CYCLES = 100
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_we_i,
  input wire logic [4:0] cfg_dly_ms_i,
  input wire logic [9:0] cfg_tmo_i,
  input wire logic cfg_std_fmt_i,
  input wire logic txd_o,
  input wire logic txd_oe_o,
  input wire logic rx_frame_end_o,
  input wire logic rx_frame_ok_o,
  input wire logic rx_bcast_o,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic reply_pending_o,
  input wire logic ext_reply_o,
  input wire logic fault_clr_i,
  input wire logic comm_timeout_fault_o,
  input wire logic [15:0] fault_code_o
);
  logic [4:0] dly;
  logic [9:0] tmo;
  logic [31:0] since;
  // A few cycles of slack absorb the registered frame-end pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dly <= mbs_pkg::RST_DLY_MS;
      tmo <= mbs_pkg::RST_TMO;
      since <= 32'h0;
    end else begin
      if (cfg_we_i && cfg_dly_ms_i <= mbs_pkg::MAX_DLY_MS) dly <= cfg_dly_ms_i;
      if (cfg_we_i && cfg_tmo_i <= mbs_pkg::MAX_TMO) tmo <= cfg_tmo_i;
      since <= rx_frame_end_o ? 32'h0 : since + 32'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rst_line_idle: assert property (disable iff (1'b0) !rst_n_i |=> txd_o && !txd_oe_o)
    else $error("line not idle after reset");
  a_fault_code_map: assert property (fault_code_o ==
    (comm_timeout_fault_o ? mbs_pkg::FAULT_COMM : mbs_pkg::FAULT_NONE))
    else $error("fault code wrong");
  a_fault_sticky: assert property (comm_timeout_fault_o && !fault_clr_i |=>
    comm_timeout_fault_o) else $error("fault dropped");
  a_fault_cause: assert property ($rose(comm_timeout_fault_o) |-> tmo != 10'h0 &&
    since + 32'h4 > 32'(int'(tmo) * 100 * MS_CYCLES)) else $error("early fault");
  a_ext_fmt: assert property (cfg_we_i |-> ##2 ext_reply_o == !$past(cfg_std_fmt_i, 2))
    else $error("reply format wrong");
  a_bcast_quiet: assert property (rx_frame_end_o && rx_bcast_o |=>
    !reply_pending_o [*4]) else $error("reply owed to broadcast");
  a_err_quiet: assert property (rx_frame_end_o && !rx_frame_ok_o |=>
    !reply_pending_o [*4]) else $error("reply owed to bad frame");
  a_tx_gate: assert property (tx_ready_o |-> reply_pending_o && !txd_oe_o)
    else $error("reply offered without cause");
  a_reply_delay: assert property (tx_ready_o |->
    since + 32'h4 >= 32'(int'(dly) * MS_CYCLES)) else $error("reply before delay");
  // Pin and enable are registered behind the shifter, so the start bit shows two edges on
  a_tx_start: assert property (tx_valid_i && tx_ready_o |-> ##2 txd_oe_o && !txd_o)
    else $error("no start bit");
  c_frame_ok: cover property (rx_frame_end_o && rx_frame_ok_o);
  c_bcast: cover property (rx_frame_end_o && rx_bcast_o);
  c_fault: cover property ($rose(comm_timeout_fault_o));
endmodule
bind mbs_slave_port mbs_slave_port_checker #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_we_i(cfg_we_i), .cfg_dly_ms_i(cfg_dly_ms_i),
  .cfg_tmo_i(cfg_tmo_i), .cfg_std_fmt_i(cfg_std_fmt_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
  .rx_frame_end_o(rx_frame_end_o), .rx_frame_ok_o(rx_frame_ok_o), .rx_bcast_o(rx_bcast_o),
  .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .reply_pending_o(reply_pending_o),
  .ext_reply_o(ext_reply_o), .fault_clr_i(fault_clr_i),
  .comm_timeout_fault_o(comm_timeout_fault_o), .fault_code_o(fault_code_o));

// >>> sim/mbs_host_model.sv
// Host master model: sends request characters and decodes reply bytes.
// Assumes the bench sets bit time and framing to match the slave.
`timescale 1ns/1ps
module mbs_host_model (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  int bit_cycles = 10;
  logic [1:0] fmt = 2'h0;
  logic [7:0] rx_q[$];
  int n_bad = 0;
  initial rxd_o = 1'b1;
  task automatic put_bit(input logic b);
    rxd_o <= b;
    repeat (bit_cycles) @(posedge clk_i);
  endtask
  task automatic send(input logic [7:0] d, input logic bad_par);
    logic p;
    p = ^d ^ (fmt == mbs_pkg::FMT_8O1) ^ bad_par;
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(d[i]);
    if (fmt == mbs_pkg::FMT_8E1 || fmt == mbs_pkg::FMT_8O1) put_bit(p);
    put_bit(1'b1);
    if (fmt == mbs_pkg::FMT_8N2) put_bit(1'b1);
  endtask
  // Idle line stays at its pull-up level; 40 bits beat any 3.5 char gap
  task automatic gap();
    repeat (40) put_bit(1'b1);
  endtask
  always begin
    logic [7:0] d;
    @(negedge txd_i);
    repeat (bit_cycles / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cycles) @(posedge clk_i);
      d[i] = txd_i;
    end
    rx_q.push_back(d);
    repeat (bit_cycles) @(posedge clk_i);
    // Parity and stop bit must follow the framing the slave was given
    if (fmt == mbs_pkg::FMT_8E1 || fmt == mbs_pkg::FMT_8O1) begin
      if (txd_i !== (^d ^ (fmt == mbs_pkg::FMT_8O1))) n_bad++;
      repeat (bit_cycles) @(posedge clk_i);
    end
    if (txd_i !== 1'b1) n_bad++;
  end
endmodule

// >>> sim/mbs_slave_port_tb.sv
// Self-checking bench of the serial slave port with a host model.
// Assumes a 100 MHz clock and a shortened time base set by CLK_HZ and MS.
`timescale 1ns/1ps
module mbs_slave_port_tb;
  localparam int CLK_HZ = 200000;
  localparam int MS = 20;
  int rate[8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  logic clk_i, rst_n_i = 1'b0, cfg_we_i = 1'b0, cfg_std_fmt_i = 1'b1, cfg_cur_res_i = 1'b0;
  logic [1:0] cfg_proto_i = '0, cfg_fmt_i = '0, m_proto = '0;
  logic [2:0] cfg_baud_i = 3'h5;
  logic [7:0] cfg_addr_i = 8'h01, tx_data_i = '0, rx_data_o, m_addr = 8'h01;
  logic [4:0] cfg_dly_ms_i = 5'h02;
  logic [9:0] cfg_tmo_i = '0;
  logic rxd, txd_o, txd_oe_o, rx_valid_o, rx_ready_i = 1'b0, rx_frame_end_o, rx_frame_ok_o;
  logic rx_bcast_o, tx_valid_i = 1'b0, tx_last_i = 1'b0, tx_ready_o, reply_pending_o;
  logic ext_reply_o, fault_clr_i = 1'b0, comm_timeout_fault_o;
  logic [15:0] current_i = '0, current_o, fault_code_o;
  logic [7:0] got[$];
  mbs_slave_port #(.CLK_HZ(CLK_HZ), .MS_CYCLES(MS)) i_mbs_slave_port (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_we_i(cfg_we_i), .cfg_proto_i(cfg_proto_i),
    .cfg_baud_i(cfg_baud_i), .cfg_fmt_i(cfg_fmt_i), .cfg_addr_i(cfg_addr_i),
    .cfg_dly_ms_i(cfg_dly_ms_i), .cfg_tmo_i(cfg_tmo_i), .cfg_std_fmt_i(cfg_std_fmt_i),
    .cfg_cur_res_i(cfg_cur_res_i), .rxd_i(rxd), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .rx_frame_end_o(rx_frame_end_o), .rx_frame_ok_o(rx_frame_ok_o), .rx_bcast_o(rx_bcast_o),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_last_i(tx_last_i),
    .tx_ready_o(tx_ready_o), .reply_pending_o(reply_pending_o), .ext_reply_o(ext_reply_o),
    .current_i(current_i), .current_o(current_o), .fault_clr_i(fault_clr_i),
    .comm_timeout_fault_o(comm_timeout_fault_o), .fault_code_o(fault_code_o));
  mbs_host_model i_mbs_host_model (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic results();
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The tests need about 87k cycles, most of them in the 300 and 600 baud passes
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 98000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cfg(input int b, f, a, d, t, s, r, p);
    @(posedge clk_i);
    cfg_baud_i <= 3'(b);
    cfg_fmt_i <= 2'(f);
    cfg_addr_i <= 8'(a);
    cfg_dly_ms_i <= 5'(d);
    cfg_tmo_i <= 10'(t);
    cfg_std_fmt_i <= 1'(s);
    cfg_cur_res_i <= 1'(r);
    cfg_proto_i <= 2'(p);
    cfg_we_i <= 1'b1;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
    if (a <= 247) m_addr = 8'(a);
    m_proto = 2'(p);
    i_mbs_host_model.bit_cycles = CLK_HZ / rate[b];
    i_mbs_host_model.fmt = 2'(f);
    repeat (3) @(posedge clk_i);
  endtask
  // Bytes pile up while the consumer stalls, then are popped one per cycle
  task automatic drain();
    rx_ready_i <= 1'b1;
    repeat (12) begin
      @(negedge clk_i);
      if (rx_valid_o === 1'b1) got.push_back(rx_data_o);
      @(posedge clk_i);
    end
    rx_ready_i <= 1'b0;
  endtask
  task automatic rf(input logic [7:0] a, input int n, input int bad);
    logic [7:0] q[$];
    int k;
    logic ok;
    q.push_back(a);
    repeat (n - 1) q.push_back(8'($urandom()));
    foreach (q[i]) i_mbs_host_model.send(q[i], i == bad);
    i_mbs_host_model.gap();
    k = ((a == m_addr || a == 8'h00) && m_proto == 2'h0) ? n : 0;
    ok = k > 0 && k <= 8 && bad < 0;
    @(negedge clk_i);
    if (m_proto == 2'h0) begin
      chk(rx_frame_ok_o, ok);
      chk(rx_bcast_o, a == 8'h00);
    end
    chk(reply_pending_o, ok && a != 8'h00);
    @(posedge clk_i);
    drain();
    if (bad < 0) begin
      chk(16'(got.size()), 16'(k > 8 ? 8 : k));
      foreach (got[i]) chk(got[i], q[i]);
    end
    got.delete();
  endtask
  task automatic reply(input logic [7:0] d);
    int t;
    t = 0;
    tx_data_i <= d;
    tx_last_i <= 1'b1;
    tx_valid_i <= 1'b1;
    do begin
      @(negedge clk_i);
      t++;
    end while (tx_ready_o !== 1'b1 && t < 20000);
    @(posedge clk_i);
    tx_valid_i <= 1'b0;
    tx_last_i <= 1'b0;
    repeat (12 * i_mbs_host_model.bit_cycles) @(posedge clk_i);
    chk(16'(i_mbs_host_model.rx_q.size()), 16'h0001);
    chk(16'(i_mbs_host_model.n_bad), 16'h0000);
    if (i_mbs_host_model.rx_q.size() > 0) chk(i_mbs_host_model.rx_q.pop_front(), d);
    chk(reply_pending_o, 1'b0);
  endtask
  initial begin
    tx_data_i = 8'($urandom(32'hae14));
    current_i = 16'($urandom());
    i_mbs_host_model.bit_cycles = CLK_HZ / rate[5];
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(ext_reply_o, 1'b0);
    chk(fault_code_o, 16'h0000);
    chk(current_o, current_i);
    rf(8'h01, 3, -1);
    reply(8'($urandom()));
    for (int f = 0; f < 4; f++) begin
      cfg(6, f, 5, 2, 0, 1, 0, 0);
      rf(8'h05, 2, -1);
      reply(8'($urandom()));
      if (f == 1 || f == 2) rf(8'h05, 2, 1);
      rf(8'h07, 2, -1);
      rf(8'h00, 2, -1);
    end
    cfg(6, 3, 248, 21, 0, 1, 0, 0);
    rf(8'h05, 2, -1);
    reply(8'($urandom()));
    cfg(6, 3, 0, 0, 0, 1, 0, 0);
    rf(8'h00, 2, -1);
    rf(8'h05, 2, -1);
    cfg(6, 3, 5, 20, 0, 1, 0, 0);
    rf(8'h05, 8, -1);
    reply(8'($urandom()));
    rf(8'h05, 9, -1);
    cfg(6, 3, 5, 2, 0, 1, 0, 1);
    rf(8'h05, 2, -1);
    cfg(6, 3, 5, 2, 0, 0, 1, 0);
    current_i <= 16'($urandom());
    repeat (3) @(posedge clk_i);
    chk(ext_reply_o, 1'b1);
    chk(current_o, current_i / 16'h000a);
    cfg(6, 3, 5, 2, 1, 1, 0, 0);
    rf(8'h05, 1, -1);
    repeat (1900) @(posedge clk_i);
    chk(comm_timeout_fault_o, 1'b0);
    repeat (200) @(posedge clk_i);
    chk(comm_timeout_fault_o, 1'b1);
    chk(fault_code_o, 16'h0010);
    cfg(6, 3, 5, 2, 0, 1, 0, 0);
    fault_clr_i <= 1'b1;
    @(posedge clk_i);
    fault_clr_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(comm_timeout_fault_o, 1'b0);
    chk(fault_code_o, 16'h0000);
    for (int b = 0; b < 8; b++) begin
      cfg(b, 3, 5, 2, 0, 1, 0, 0);
      rf(8'h05, 1, -1);
    end
    results();
  end
endmodule
